// ===== inc/dee_defs.svh
// Constants for the data EEPROM access block.
// Assumes inclusion by bare name from the package and design files.
`ifndef DEE_DEFS_SVH
`define DEE_DEFS_SVH
`define DEE_BASE_ADDR   24'h7ffe00
`define DEE_TOP_ADDR    24'h7fffff
`define DEE_DEPTH       256
`define DEE_AW          8
`define DEE_DW          16
`define DEE_KEY_FIRST   8'h55
`define DEE_KEY_SECOND  8'haa
`define DEE_CTL_RESET   16'h0000
`define DEE_PAGE        8'h7f
`define DEE_ERASED      16'hffff
`define DEE_CTL_START   15
`define DEE_CTL_ENABLE  14
`define DEE_CTL_ERR     13
`define DEE_CTL_ERASE   6
`define DEE_CTL_OPLO    0
`define DEE_CTL_OPHI    5
`define DEE_OP_WORD     6'h04
`define DEE_PROG_NS     4000
`define DEE_PROG_CYC    ((`DEE_PROG_NS + 9) / 10)
`endif

// ===== inc/dee_pkg.sv
// Types for the data EEPROM access block.
// Assumes dee_defs.svh is reachable on the include path.
`default_nettype none
package dee_pkg;
  `include "dee_defs.svh"
  typedef enum logic [2:0] {
    DEE_IDLE  = 3'b001,
    DEE_BUSY  = 3'b010,
    DEE_DONE  = 3'b100
  } dee_state_e;
  typedef enum logic [1:0] {
    DEE_LK_LOCKED = 2'b01,
    DEE_LK_ARMED  = 2'b10
  } dee_key_e;
endpackage
`default_nettype wire

// ===== verilog/dee_ctrl.sv
// Data EEPROM controller: unlock key, control word, address, array and read ports.
// Assumes the core drives register strobes and read requests on mclk_i.
`default_nettype none
`include "dee_defs.svh"
// Contract
// - Array occupies program addresses 7FFE00h to 7FFFFFh.
// - Array holds 256 words.
// - Words are 16 bits, individually addressable, readable and writable.
// - Program or erase runs without stalling the core.
// - Control, unlock key and address registers govern operations.
// - Control upper byte holds start bit and error flag.
// - Control lower byte selects operation type.
// - Unlock key register is write-only guard storage.
// - Only the ordered pair 55h then AAh unlocks.
// - Control write accepted only in the one cycle after unlock.
// - Setting the start and enable bits in that window launches the operation.
// - Word read uses a low table read with page and offset.
// - Array is also readable through the program space window.
// - Control register resets only on power-on reset.
module dee_ctrl
  import dee_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        por_i,
  input  wire logic        key_wr_i,
  input  wire logic [7:0]  key_data_i,
  input  wire logic        ctl_wr_i,
  input  wire logic [15:0] ctl_data_i,
  input  wire logic        adr_wr_i,
  input  wire logic [15:0] adr_data_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        tbl_rd_i,
  input  wire logic [7:0]  tbl_page_i,
  input  wire logic [15:0] tbl_offset_i,
  input  wire logic        psv_rd_i,
  input  wire logic [15:0] psv_offset_i,
  output logic [15:0]      ctl_o,
  output logic [15:0]      adr_o,
  output logic [15:0]      rdata_o,
  output logic             rvalid_o,
  output logic             rmiss_o,
  output logic             busy_o
);
  logic [`DEE_DW-1:0] mem [0:`DEE_DEPTH-1];
  logic [15:0]  ctl_reg;
  logic [15:0]  adr_reg;
  logic [15:0]  wlat_reg;
  logic [15:0]  rdata_reg;
  logic         rvalid_reg;
  logic         rmiss_reg;
  logic [15:0]  cnt_reg;
  dee_state_e   st_reg;
  dee_key_e     key_reg;

  // The array answers when the 24-bit address falls in its window.
  function automatic logic in_window(input logic [23:0] a);
    in_window = (a >= `DEE_BASE_ADDR) && (a <= `DEE_TOP_ADDR);
  endfunction

  // Program words are two address units apart, so bit 0 is dropped.
  function automatic logic [`DEE_AW-1:0] word_idx(input logic [23:0] a);
    word_idx = a[`DEE_AW:1];
  endfunction

  wire [23:0] tbl_addr   = {tbl_page_i, tbl_offset_i};
  // The window sees page 7Fh; offsets in the upper half of data space map there.
  wire [23:0] psv_addr   = {`DEE_PAGE, psv_offset_i};
  wire        rd_req     = tbl_rd_i | psv_rd_i;
  wire [23:0] rd_addr    = tbl_rd_i ? tbl_addr : psv_addr;
  wire        rd_hit     = in_window(rd_addr);
  wire        key_first  = key_wr_i && (key_data_i == `DEE_KEY_FIRST);
  wire        key_second = key_wr_i && (key_data_i == `DEE_KEY_SECOND);
  logic       armed_reg;
  wire        unlocked   = armed_reg;
  wire        ctl_take   = ctl_wr_i && unlocked && (st_reg == DEE_IDLE);
  wire        launch     = ctl_take && ctl_data_i[`DEE_CTL_START]
                           && ctl_data_i[`DEE_CTL_ENABLE];
  wire [`DEE_AW-1:0] tgt = word_idx({`DEE_PAGE, adr_reg});
  wire        adr_ok     = in_window({`DEE_PAGE, adr_reg});
  wire        finish     = (st_reg == DEE_BUSY) && (cnt_reg == 16'h0000);
  wire        is_erase   = ctl_reg[`DEE_CTL_ERASE];

  // Key sequencer: a control write or any other key value drops back to locked.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      key_reg   <= DEE_LK_LOCKED;
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= (key_reg == DEE_LK_ARMED) && key_second;
      if (key_wr_i || ctl_wr_i) begin
        key_reg <= key_first ? DEE_LK_ARMED : DEE_LK_LOCKED;
      end
    end
  end

  // The control word survives ordinary resets and clears only on power-on.
  always_ff @(posedge mclk_i) begin
    if (por_i) begin
      ctl_reg <= `DEE_CTL_RESET;
    end else if (finish) begin
      ctl_reg[`DEE_CTL_START] <= 1'b0;
      ctl_reg[`DEE_CTL_ERR]   <= ~adr_ok;
    end else if (ctl_take) begin
      ctl_reg <= ctl_data_i;
      ctl_reg[`DEE_CTL_START] <= launch;
      ctl_reg[`DEE_CTL_ERR]   <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      adr_reg  <= 16'h0000;
      wlat_reg <= 16'h0000;
    end else if (adr_wr_i && (st_reg == DEE_IDLE)) begin
      adr_reg  <= adr_data_i;
      wlat_reg <= wdata_i;
    end
  end

  // The cycle runs in the background; reads stay open throughout.
  // Only power-on stops a running cycle, since an ordinary reset keeps the
  // start bit and would otherwise leave it set with no cycle to clear it.
  always_ff @(posedge mclk_i) begin
    if (por_i) begin
      st_reg  <= DEE_IDLE;
      cnt_reg <= 16'h0000;
    end else begin
      case (st_reg)
        DEE_IDLE: begin
          if (launch) begin
            st_reg  <= DEE_BUSY;
            cnt_reg <= 16'(`DEE_PROG_CYC - 1);
          end
        end
        DEE_BUSY: begin
          if (cnt_reg == 16'h0000) begin
            st_reg <= DEE_DONE;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        DEE_DONE: st_reg <= DEE_IDLE;
        default:  st_reg <= DEE_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (finish && adr_ok) begin
      mem[tgt] <= is_erase ? `DEE_ERASED : wlat_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
      rmiss_reg  <= 1'b0;
    end else begin
      rvalid_reg <= rd_req && rd_hit;
      rmiss_reg  <= rd_req && !rd_hit;
      rdata_reg  <= (rd_req && rd_hit) ? mem[word_idx(rd_addr)] : 16'h0000;
    end
  end

  assign ctl_o    = ctl_reg;
  assign adr_o    = adr_reg;
  assign rdata_o  = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign rmiss_o  = rmiss_reg;
  assign busy_o   = ctl_reg[`DEE_CTL_START];

  chk_unlock_pair: assert property (@(posedge mclk_i) disable iff (srst_i)
    key_first ##1 (key_second && !ctl_wr_i) |=> armed_reg)
    else $error("unlock pair did not arm control window");
  chk_lock_after: assert property (@(posedge mclk_i) disable iff (srst_i)
    armed_reg |=> !armed_reg)
    else $error("control window stayed open past one cycle");
  chk_locked_write: assert property (@(posedge mclk_i) disable iff (srst_i || por_i)
    (ctl_wr_i && !armed_reg && !finish) |=> $stable(ctl_reg))
    else $error("locked control write changed control word");
  chk_launch_busy: assert property (@(posedge mclk_i) disable iff (srst_i || por_i)
    launch |=> (st_reg == DEE_BUSY) && ctl_reg[`DEE_CTL_START])
    else $error("launch did not start the cycle");
  chk_start_clear: assert property (@(posedge mclk_i) disable iff (srst_i || por_i)
    finish |=> !ctl_reg[`DEE_CTL_START])
    else $error("start bit not cleared at finish");
  chk_read_window: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_req && (rd_addr < `DEE_BASE_ADDR)) |=> !rvalid_reg && rmiss_reg)
    else $error("read below window answered");
  chk_read_busy: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_reg == DEE_BUSY && rd_req && rd_hit) |=> rvalid_reg)
    else $error("read stalled during cycle");
  chk_por_clear: assert property (@(posedge mclk_i)
    por_i |=> ctl_reg == `DEE_CTL_RESET)
    else $error("power-on did not clear control word");

  // The unlock pair and the run of a launched cycle are multi-step, so they
  // are written as named sequences and reused by the properties below.
  sequence s_key_pair;
    key_first ##1 key_second;
  endsequence

  // A launched cycle stays busy and finishes exactly 400 cycles after launch.
  sequence s_cycle_end;
    (st_reg == DEE_BUSY) [*8] ##[392:392] finish;
  endsequence

  chk_pair_arms: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_key_pair
    |=> armed_reg)
    else $error("ordered key pair did not open the window");

  chk_arm_source: assert property (@(posedge mclk_i) disable iff (srst_i)
    armed_reg
    |-> $past(key_second))
    else $error("window opened without second key");

  chk_wrong_key: assert property (@(posedge mclk_i) disable iff (srst_i)
    (key_wr_i && !key_first)
    |=> key_reg == DEE_LK_LOCKED)
    else $error("wrong key value left sequencer armed");

  chk_cycle_time: assert property (@(posedge mclk_i) disable iff (por_i)
    launch
    |=> s_cycle_end)
    else $error("cycle length differs from program time");

  chk_busy_state: assert property (@(posedge mclk_i) disable iff (por_i)
    1'b1
    |-> ctl_reg[`DEE_CTL_START] == (st_reg == DEE_BUSY))
    else $error("start bit disagrees with cycle state");

  chk_no_start_locked: assert property (@(posedge mclk_i) disable iff (por_i)
    (st_reg == DEE_IDLE && !launch)
    |=> st_reg != DEE_BUSY)
    else $error("cycle began without a launch");

  chk_enable_needed: assert property (@(posedge mclk_i) disable iff (por_i)
    (ctl_take && !ctl_data_i[`DEE_CTL_ENABLE])
    |=> !ctl_reg[`DEE_CTL_START])
    else $error("launch taken without enable bit");

  chk_busy_ctl_refused: assert property (@(posedge mclk_i) disable iff (por_i)
    (ctl_wr_i && st_reg != DEE_IDLE)
    |=> $stable(ctl_reg[`DEE_CTL_OPHI:`DEE_CTL_OPLO]))
    else $error("control write taken while busy");

  chk_err_flag: assert property (@(posedge mclk_i) disable iff (por_i)
    finish
    |=> ctl_reg[`DEE_CTL_ERR] == !$past(adr_ok))
    else $error("error flag wrong at finish");

  chk_onehot_state: assert property (@(posedge mclk_i) disable iff (por_i)
    1'b1
    |-> $onehot(st_reg))
    else $error("cycle state not one-hot");

  chk_done_idle: assert property (@(posedge mclk_i) disable iff (por_i)
    st_reg == DEE_DONE
    |=> st_reg == DEE_IDLE)
    else $error("done state did not return to idle");

  chk_count_range: assert property (@(posedge mclk_i) disable iff (por_i)
    st_reg == DEE_BUSY
    |-> cnt_reg <= 16'(`DEE_PROG_CYC - 1))
    else $error("cycle counter out of range");

  // Array contents have no reset, so these two watch every edge.
  chk_write_land: assert property (@(posedge mclk_i)
    (finish && adr_ok && !is_erase)
    |=> mem[$past(tgt)] == $past(wlat_reg))
    else $error("program cycle did not store latched word");

  chk_erase_fill: assert property (@(posedge mclk_i)
    (finish && adr_ok && is_erase)
    |=> mem[$past(tgt)] == `DEE_ERASED)
    else $error("erase cycle did not clear the word");

  chk_adr_load: assert property (@(posedge mclk_i) disable iff (srst_i)
    (adr_wr_i && st_reg == DEE_IDLE)
    |=> adr_reg == $past(adr_data_i))
    else $error("address write not taken while idle");

  chk_busy_adr_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    (adr_wr_i && st_reg != DEE_IDLE)
    |=> $stable(adr_reg))
    else $error("address changed during a cycle");

  chk_read_hit: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_req && rd_hit)
    |=> rvalid_reg && !rmiss_reg)
    else $error("read inside window not answered");

  chk_miss_data: assert property (@(posedge mclk_i) disable iff (srst_i)
    (rd_req && !rd_hit)
    |=> rdata_reg == 16'h0000 && !rvalid_reg)
    else $error("read outside window returned data");

  // An ordinary reset must leave the control word alone.
  chk_srst_keeps_ctl: assert property (@(posedge mclk_i) disable iff (por_i)
    (srst_i && !finish && !ctl_take)
    |=> $stable(ctl_reg))
    else $error("ordinary reset changed control word");
endmodule
`default_nettype wire

// ===== verification/dee_core_model.sv
// Core model: register write strobes and table or window reads.
// Assumes one shared clock; requests change on the falling edge.
`default_nettype none
module dee_core_model (
  input  wire logic        mclk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  input  wire logic        rmiss_i,
  output logic             key_wr_o,
  output logic             ctl_wr_o,
  output logic             adr_wr_o,
  output logic             tbl_rd_o,
  output logic             psv_rd_o,
  output logic [15:0]      dat_o,
  output logic [15:0]      wd_o,
  output logic [7:0]       page_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {key_wr_o, ctl_wr_o, adr_wr_o, tbl_rd_o, psv_rd_o, dat_o, wd_o, page_o} = '0;
  // Nothing may split key pair and control write, as with interrupts held off.
  task automatic unlock(input logic [7:0] a, b, input logic [15:0] c, input int gap);
    @(negedge mclk_i);
    {key_wr_o, dat_o} = {9'h100, a};
    @(negedge mclk_i);
    dat_o = {8'h00, b};
    repeat (gap) @(negedge mclk_i) {key_wr_o, dat_o} = {1'b0, ~c};
    @(negedge mclk_i);
    {key_wr_o, ctl_wr_o, dat_o} = {2'b01, c};
    @(negedge mclk_i);
    {ctl_wr_o, dat_o} = {1'b0, ~c};
  endtask
  task automatic setadr(input logic [15:0] a, d);
    @(negedge mclk_i);
    {adr_wr_o, dat_o, wd_o} = {1'b1, a, d};
    @(negedge mclk_i);
    {adr_wr_o, dat_o, wd_o} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic t, input logic [7:0] p, input logic [15:0] o,
                    output logic [15:0] d, output logic [1:0] hm);
    @(negedge mclk_i);
    {tbl_rd_o, psv_rd_o, page_o, dat_o} = {t, !t, p, o};
    @(negedge mclk_i);
    {tbl_rd_o, psv_rd_o, page_o, dat_o} = {2'b00, ~p, ~o};
    if ((rvalid_i | rmiss_i) !== 1'b1) @(negedge mclk_i);
    d  = rdata_i;
    hm = {rvalid_i, rmiss_i};
  endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Bench for the data EEPROM controller, driven through the core model.
// Assumes the controller and the core model are compiled first.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 1'b0, srst_i = 1'b1, por_i = 1'b1;
  logic kw, cw, aw, tr, pr, rv, rm, busy;
  logic [7:0] pg;
  logic [15:0] dat, wd, ctl, adr, rdata, d;
  logic [1:0] hm;
  int n_errors = 0, comparisons = 0, cyc = 0, n;
  always #5 mclk_i = ~mclk_i;
  dee_ctrl i_dut (.mclk_i, .srst_i, .por_i, .key_wr_i(kw), .key_data_i(dat[7:0]),
    .ctl_wr_i(cw), .ctl_data_i(dat), .adr_wr_i(aw), .adr_data_i(dat), .wdata_i(wd),
    .tbl_rd_i(tr), .tbl_page_i(pg), .tbl_offset_i(dat), .psv_rd_i(pr), .psv_offset_i(dat),
    .ctl_o(ctl), .adr_o(adr), .rdata_o(rdata), .rvalid_o(rv), .rmiss_o(rm), .busy_o(busy));
  dee_core_model core (.mclk_i, .rdata_i(rdata), .rvalid_i(rv), .rmiss_i(rm), .key_wr_o(kw),
    .ctl_wr_o(cw), .adr_wr_o(aw), .tbl_rd_o(tr), .psv_rd_o(pr), .dat_o(dat), .wd_o(wd),
    .page_o(pg));
  task automatic chk(input string s, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // A cycle takes about 400 clocks; the cap of 600 keeps a stuck flag from hanging.
  task automatic idle;
    @(negedge mclk_i);
    for (n = 1; busy !== 1'b0 && n < 600; n++) @(negedge mclk_i);
  endtask
  task automatic t_program;
    core.setadr(16'hfffe, 16'h1234);
    chk("adr", 16'hfffe, adr);
    core.unlock(8'h55, 8'haa, 16'hc004, 0);
    @(negedge mclk_i);
    chk("busy", 16'h1, busy);
    core.rd(1'b1, 8'h7f, 16'hfe00, d, hm);
    chk("rd_busy", 16'h2, hm);
    idle;
    chk("time", 16'h1, n > 380 && n < 420);
    chk("ctl", 16'h0004, {ctl[15], ctl[13], ctl[5:0]});
    core.rd(1'b1, 8'h7f, 16'hfffe, d, hm);
    chk("tbl", 16'h1234, d);
    core.rd(1'b0, 8'h00, 16'hfffe, d, hm);
    chk("psv", 16'h1234, d);
  endtask
  task automatic t_refuse;
    core.unlock(8'haa, 8'h55, 16'hc044, 0);
    chk("order", 16'h0, busy);
    core.unlock(8'h55, 8'haa, 16'hc044, 1);
    chk("late", 16'h0, busy);
    core.unlock(8'h55, 8'haa, 16'hc044, 0);
    idle;
    core.rd(1'b1, 8'h7f, 16'hfffe, d, hm);
    chk("erase", 16'hffff, d);
  endtask
  task automatic t_error_reset;
    core.setadr(16'h0002, 16'h5a5a);
    core.unlock(8'h55, 8'haa, 16'hc004, 0);
    idle;
    chk("err", 16'h1, ctl[13]);
    core.rd(1'b1, 8'h00, 16'hfffe, d, hm);
    chk("miss", 16'h1, hm);
    core.rd(1'b1, 8'h7f, 16'hfdfe, d, hm);
    chk("below", 16'h1, hm);
    core.unlock(8'h55, 8'haa, 16'hc004, 0);
    @(negedge mclk_i) srst_i = 1'b1;
    @(negedge mclk_i) srst_i = 1'b0;
    chk("srst", 16'h0044, {ctl[15], ctl[5:0]});
    idle;
    chk("srst_run", 16'h0, busy);
    @(negedge mclk_i) por_i = 1'b1;
    @(negedge mclk_i) por_i = 1'b0;
    chk("por", 16'h0, ctl);
  endtask
  initial begin
    repeat (8) @(negedge mclk_i);
    {srst_i, por_i} = 2'b00;
    t_program;
    t_refuse;
    t_error_reset;
    results;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      results;
    end
  end
endmodule
`default_nettype wire
